// [sppm_cfg.svh]
// Constants for the switch port power management block
`ifndef SPPM_CFG_SVH
`define SPPM_CFG_SVH
`define SPPM_PS_D0        2'h0
`define SPPM_PS_D3HOT     2'h3
`define SPPM_CONTEXT_KEPT 1'h1
`define SPPM_TMR_W        24
`define SPPM_NPORTS       4
`endif

// [sppm_pkg.sv]
// Types for the switch port power management block
package sppm_pkg;
   typedef enum logic [1:0] {
      SPPM_D0_UNINIT = 2'b00,
      SPPM_D0_ACTIVE = 2'b01,
      SPPM_D3_HOT    = 2'b10
   } sppm_pstate_type;
   typedef enum logic [1:0] {
      SPPM_AG_IDLE    = 2'b00,
      SPPM_AG_COLLECT = 2'b01,
      SPPM_AG_DONE    = 2'b10,
      SPPM_AG_ABANDON = 2'b11
   } sppm_agg_type;
endpackage

// [sppm_port.sv]
// One port: power state, wake resend timer and turn-off ack timer
`timescale 1ns/1ps
`include "sppm_cfg.svh"
module sppm_port #(
   parameter int TW = `SPPM_TMR_W
) (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   resetn,
   // Configuration
   input  wire logic                   cfg_done,
   input  wire logic                   ps_wr,
   input  wire logic [1:0]             ps_wdata,
   input  wire logic [TW-1:0]          wake_resend_timeout,
   input  wire logic [TW-1:0]          turnoff_ack_timeout,
   input  wire logic                   is_downstream,
   // Wake events
   input  wire logic                   hp_event,
   input  wire logic                   wake_status_clr,
   input  wire logic                   switch_d3hot,
   // Turn-off
   input  wire logic                   turnoff_fwd,
   input  wire logic                   ack_rx,
   // Results
   output sppm_pkg::sppm_pstate_type   pstate,
   output logic                        wake_event_status,
   output logic                        wake_send,
   output logic                        ack_seen,
   output logic                        ack_timeout
);
   import sppm_pkg::*;

   sppm_pstate_type next_pstate;
   logic            next_wes;
   logic            next_send;
   logic [TW-1:0]   wtmr;
   logic [TW-1:0]   next_wtmr;
   logic            await_ack;
   logic            next_await;
   logic [TW-1:0]   atmr;
   logic [TW-1:0]   next_atmr;
   logic            next_seen;
   logic            next_to;
   logic            in_d3;

   assign in_d3 = (pstate == SPPM_D3_HOT) || switch_d3hot;

   // ***********************************
   // Power state and wake resend
   // ***********************************
   always_comb begin
      next_pstate = pstate;
      if (pstate == SPPM_D0_UNINIT && cfg_done) begin
         next_pstate = SPPM_D0_ACTIVE;
      end
      // Unsupported codes leave the state alone
      if (ps_wr) begin
         if (pstate == SPPM_D0_ACTIVE && ps_wdata == `SPPM_PS_D3HOT) begin
            next_pstate = SPPM_D3_HOT;
         end else if (pstate == SPPM_D3_HOT && ps_wdata == `SPPM_PS_D0) begin
            // The port returns uninitialised and waits for cfg_done again
            next_pstate = SPPM_D0_UNINIT;
         end
      end
      next_send = 1'b0;
      next_wes  = wake_event_status;
      next_wtmr = wtmr;
      if (wake_event_status && wtmr != '0) begin
         next_wtmr = wtmr - 1'b1;
         if (wtmr == {{(TW-1){1'b0}}, 1'b1} && !wake_status_clr) begin
            next_send = 1'b1;
            next_wtmr = wake_resend_timeout;
         end
      end
      // Clear after the count, so a stopped timer really reads zero
      if (wake_status_clr) begin
         next_wes  = 1'b0;
         next_wtmr = '0;
      end
      // Set wins over clear
      if (hp_event && is_downstream && in_d3) begin
         next_wes  = 1'b1;
         next_send = 1'b1;
         next_wtmr = wake_resend_timeout;
      end
   end

   // ***********************************
   // Turn-off ack timer
   // ***********************************
   always_comb begin
      next_await = await_ack;
      next_atmr  = atmr;
      next_seen  = 1'b0;
      next_to    = 1'b0;
      if (turnoff_fwd) begin
         next_await = 1'b1;
         next_atmr  = turnoff_ack_timeout;
      end else if (await_ack) begin
         if (ack_rx) begin
            next_await = 1'b0;
            next_seen  = 1'b1;
            next_atmr  = '0;
         end else if (atmr <= {{(TW-1){1'b0}}, 1'b1}) begin
            next_await = 1'b0;
            next_seen  = 1'b1;
            next_to    = 1'b1;
            next_atmr  = '0;
         end else begin
            next_atmr = atmr - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pstate            <= SPPM_D0_UNINIT;
         wake_event_status <= 1'b0;
         wake_send         <= 1'b0;
         wtmr              <= '0;
         await_ack         <= 1'b0;
         atmr              <= '0;
         ack_seen          <= 1'b0;
         ack_timeout       <= 1'b0;
      end else begin
         pstate            <= next_pstate;
         wake_event_status <= next_wes;
         wake_send         <= next_send;
         wtmr              <= next_wtmr;
         await_ack         <= next_await;
         atmr              <= next_atmr;
         ack_seen          <= next_seen;
         ack_timeout       <= next_to;
      end
   end
endmodule

// [sppm_top.sv]
// Switch power management: per-port states, wake resend, turn-off fence
`timescale 1ns/1ps
`include "sppm_cfg.svh"
module sppm_top
   import sppm_pkg::*;
#(
   parameter int NP = `SPPM_NPORTS,
   parameter int TW = `SPPM_TMR_W
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  resetn,
   // Per-port configuration, port 0 is upstream
   input  wire logic [NP-1:0]         cfg_done,
   input  wire logic [NP-1:0]         ps_wr,
   input  wire logic [2*NP-1:0]       power_state_field,
   input  wire logic [NP*TW-1:0]      wake_resend_timeout,
   input  wire logic [NP*TW-1:0]      turnoff_ack_timeout,
   input  wire logic [NP-1:0]         wake_status_clr,
   input  wire logic [NP-1:0]         hp_event,
   // Link status and turn-off messages
   input  wire logic [NP-1:0]         link_active,
   input  wire logic [NP-1:0]         link_in_l0,
   input  wire logic                  turnoff_rx,
   input  wire logic [NP-1:0]         ack_rx,
   // Received TLP classification
   input  wire logic [NP-1:0]         tlp_rx,
   input  wire logic [NP-1:0]         tlp_secondary,
   input  wire logic [NP-1:0]         tlp_is_request,
   input  wire logic [NP-1:0]         tlp_cfg0,
   input  wire logic [NP-1:0]         tlp_msg_local,
   input  wire logic [NP-1:0]         tlp_cpl_local,
   input  wire logic                  tlp_to_switch,
   input  wire logic [NP-1:0]         tlp_dest,
   input  wire logic [NP-1:0]         err_from_tlp,
   input  wire logic [NP-1:0]         err_other,
   // Results
   output logic [NP-1:0]              context_kept_flag,
   output logic [2*NP-1:0]            pstate_out,
   output logic [NP-1:0]              wake_event_status,
   output logic [NP-1:0]              wake_msg_send,
   output logic [NP-1:0]              link_l1_req,
   output logic [NP-1:0]              turnoff_fwd,
   output logic [NP-1:0]              link_l23_req,
   output logic [NP-1:0]              link_retrain,
   output logic [NP-1:0]              tlp_forward,
   output logic                       ack_tx,
   output logic                       switch_low_power,
   output logic                       agg_abandoned,
   output logic [NP-1:0]              tlp_unsupported,
   output logic [NP-1:0]              tlp_unexpected_cpl,
   output logic [NP-1:0]              tlp_process,
   output logic [NP-1:0]              err_msg_send
);
   import sppm_pkg::*;

   sppm_pstate_type ps [NP];
   logic [NP-1:0]   wes;
   logic [NP-1:0]   wsend;
   logic [NP-1:0]   seen;
   logic [NP-1:0]   tmo;
   logic [NP-1:0]   d3;
   logic [NP-1:0]   pending;
   logic [NP-1:0]   next_pending;
   logic [NP-1:0]   ds_mask;
   sppm_agg_type    agg;
   sppm_agg_type    next_agg;
   logic            next_ack_tx;
   logic            next_lowp;
   logic            next_aband;
   logic [NP-1:0]   next_fwd_to;
   logic [NP-1:0]   next_l23;
   logic [NP-1:0]   next_retrain;
   logic [NP-1:0]   next_fwd;
   logic [NP-1:0]   next_ur;
   logic [NP-1:0]   next_uc;
   logic [NP-1:0]   next_proc;
   logic [NP-1:0]   next_err;
   logic [NP-1:0]   retrain_hold;
   logic [NP-1:0]   next_hold;

   // Port 0 faces the root and never sends wake messages
   assign ds_mask = {{(NP-1){1'b1}}, 1'b0};

   // ***********************************
   // Per-port state machines
   // ***********************************
   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_port
         sppm_port #(.TW(TW)) u_port (
            .mclk                (mclk),
            .resetn              (resetn),
            .cfg_done            (cfg_done[g]),
            .ps_wr               (ps_wr[g]),
            .ps_wdata            (power_state_field[2*g+:2]),
            .wake_resend_timeout (wake_resend_timeout[TW*g+:TW]),
            .turnoff_ack_timeout (turnoff_ack_timeout[TW*g+:TW]),
            .is_downstream       (ds_mask[g]),
            .hp_event            (hp_event[g]),
            .wake_status_clr     (wake_status_clr[g]),
            .switch_d3hot        (d3[0]),
            .turnoff_fwd         (next_fwd_to[g]),
            .ack_rx              (ack_rx[g]),
            .pstate              (ps[g]),
            .wake_event_status   (wes[g]),
            .wake_send           (wsend[g]),
            .ack_seen            (seen[g]),
            .ack_timeout         (tmo[g])
         );
         assign d3[g] = (ps[g] == SPPM_D3_HOT);
      end
   endgenerate

   // ***********************************
   // Turn-off fence and D3hot filtering
   // ***********************************
   always_comb begin
      next_agg     = agg;
      next_pending = pending & ~seen;
      next_ack_tx  = 1'b0;
      next_lowp    = switch_low_power;
      next_aband   = 1'b0;
      next_fwd_to  = '0;
      next_l23     = link_l23_req & ~link_retrain;
      next_hold    = retrain_hold;
      next_retrain = '0;
      next_fwd     = '0;
      next_ur      = '0;
      next_uc      = '0;
      next_proc    = '0;
      next_err     = '0;
      for (int i = 0; i < NP; i++) begin
         if (tmo[i]) begin
            next_l23[i] = 1'b1;
         end
         if (seen[i]) begin
            next_l23[i] = 1'b1;
         end
      end
      case (agg)
         SPPM_AG_IDLE: begin
            if (turnoff_rx) begin
               next_fwd_to  = link_active & ds_mask;
               next_pending = link_active & ds_mask;
               next_agg     = SPPM_AG_COLLECT;
            end
         end
         SPPM_AG_COLLECT: begin
            if (tlp_rx[0]) begin
               next_agg   = SPPM_AG_ABANDON;
               next_aband = 1'b1;
            end else if (next_pending == '0) begin
               next_ack_tx = 1'b1;
               next_l23[0] = 1'b1;
               next_agg    = SPPM_AG_DONE;
               next_lowp   = d3[0];
            end
         end
         SPPM_AG_DONE: begin
            // Late upstream TLPs are dropped in this state; downstream TLPs are still handled
            if (turnoff_rx) begin
               next_agg = SPPM_AG_IDLE;
            end
         end
         default: begin
            // Downstream timers keep running
            if (turnoff_rx) begin
               next_fwd_to  = link_active & ds_mask;
               next_pending = link_active & ds_mask;
               next_agg     = SPPM_AG_COLLECT;
            end
         end
      endcase
      // Upstream TLP routing in every state except SPPM_AG_DONE
      if (agg != SPPM_AG_DONE && tlp_rx[0] && !tlp_to_switch) begin
         for (int i = 1; i < NP; i++) begin
            if (tlp_dest[i] && !link_in_l0[i]) begin
               next_hold[i] = 1'b1;
            end
         end
      end
      // Hold parks the TLP until its link is back in L0
      for (int i = 1; i < NP; i++) begin
         if (next_hold[i] && !link_in_l0[i]) begin
            next_retrain[i] = 1'b1;
         end
         if ((next_hold[i] || retrain_hold[i]) && link_in_l0[i]) begin
            next_fwd[i]  = 1'b1;
            next_hold[i] = 1'b0;
         end else if (agg != SPPM_AG_DONE && tlp_rx[0] &&
                      !tlp_to_switch && tlp_dest[i] && link_in_l0[i]) begin
            next_fwd[i] = 1'b1;
         end
      end
      for (int i = 0; i < NP; i++) begin
         if (tlp_rx[i] && !(agg == SPPM_AG_DONE && i == 0)) begin
            if (!d3[i]) begin
               next_proc[i] = tlp_is_request[i] || tlp_cpl_local[i];
            end else if (tlp_is_request[i] && tlp_secondary[i]) begin
               next_ur[i] = 1'b1;
            end else if (tlp_is_request[i]) begin
               if (tlp_cfg0[i] || tlp_msg_local[i]) begin
                  next_proc[i] = 1'b1;
               end else begin
                  next_ur[i] = 1'b1;
               end
            end else if (tlp_cpl_local[i]) begin
               next_uc[i] = 1'b1;
            end
         end
         // Only TLP-caused errors escape D3hot
         next_err[i] = err_from_tlp[i] ||
                       (err_other[i] && !d3[i]);
      end
      // Upstream leaving D3hot wakes the whole switch
      if (ps[0] != SPPM_D3_HOT) begin
         next_lowp = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         agg                <= SPPM_AG_IDLE;
         pending            <= '0;
         ack_tx             <= 1'b0;
         switch_low_power   <= 1'b0;
         agg_abandoned      <= 1'b0;
         turnoff_fwd        <= '0;
         link_l23_req       <= '0;
         link_retrain       <= '0;
         retrain_hold       <= '0;
         tlp_forward        <= '0;
         tlp_unsupported    <= '0;
         tlp_unexpected_cpl <= '0;
         tlp_process        <= '0;
         err_msg_send       <= '0;
      end else begin
         agg                <= next_agg;
         pending            <= next_pending;
         ack_tx             <= next_ack_tx;
         switch_low_power   <= next_lowp;
         agg_abandoned      <= next_aband;
         turnoff_fwd        <= next_fwd_to;
         link_l23_req       <= next_l23;
         link_retrain       <= next_retrain;
         retrain_hold       <= next_hold;
         tlp_forward        <= next_fwd;
         tlp_unsupported    <= next_ur;
         tlp_unexpected_cpl <= next_uc;
         tlp_process        <= next_proc;
         err_msg_send       <= next_err;
      end
   end

   // ***********************************
   // Registered status outputs
   // ***********************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         context_kept_flag <= '0;
         pstate_out        <= '0;
         wake_event_status <= '0;
         wake_msg_send     <= '0;
         link_l1_req       <= '0;
      end else begin
         // Context survives D3hot, so the flag is fixed high
         for (int i = 0; i < NP; i++) begin
            context_kept_flag[i] <= `SPPM_CONTEXT_KEPT;
            pstate_out[2*i+:2]   <= ps[i];
            link_l1_req[i]       <= d3[i];
         end
         wake_event_status <= wes;
         wake_msg_send     <= wsend & ds_mask;
      end
   end
endmodule

// [sppm_far_end.sv]
// Behavioural link partners that answer the forwarded turn-off
`timescale 1ns/1ps
module sppm_far_end #(
   parameter int NP = 4
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          resetn,
   // Turn-off and reply delay per port, zero keeps the port silent
   input  wire logic [NP-1:0] turnoff_fwd,
   input  wire logic [7:0]    ack_delay [NP],
   // Acknowledge pulses towards the switch
   output logic      [NP-1:0] ack_rx
);
   // ****************************************
   // Reply timers
   // ****************************************
   logic [7:0]    cnt [NP];
   logic [7:0]    next_cnt [NP];
   logic [NP-1:0] next_ack_rx;

   // Acks keep coming after an abandoned aggregation
   always_comb begin
      for (int i = 0; i < NP; i++) begin
         next_cnt[i] = (cnt[i] != 8'h0) ? cnt[i] - 8'h1 : 8'h0;
         next_ack_rx[i] = (cnt[i] == 8'h1);
         if (turnoff_fwd[i]) begin
            next_cnt[i] = ack_delay[i];
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         cnt <= '{default: 8'h0};
         ack_rx <= '0;
      end else begin
         cnt <= next_cnt;
         ack_rx <= next_ack_rx;
      end
   end
endmodule

// [sppm_top_monitor.sv]
// Port checker for the power management block, bound to its top
`timescale 1ns/1ps
module sppm_top_monitor #(
   parameter int NP = 4
) (
   // Clock and reset
   input  wire logic            mclk,
   input  wire logic            resetn,
   // Watched inputs
   input  wire logic [NP-1:0]   ps_wr,
   input  wire logic [2*NP-1:0] power_state_field,
   input  wire logic            turnoff_rx,
   input  wire logic [NP-1:0]   link_active,
   input  wire logic [NP-1:0]   tlp_rx,
   input  wire logic [NP-1:0]   tlp_secondary,
   input  wire logic [NP-1:0]   tlp_is_request,
   // Watched outputs
   input  wire logic [NP-1:0]   context_kept_flag,
   input  wire logic [2*NP-1:0] pstate_out,
   input  wire logic [NP-1:0]   link_l1_req,
   input  wire logic [NP-1:0]   turnoff_fwd,
   input  wire logic [NP-1:0]   link_l23_req,
   input  wire logic            ack_tx,
   input  wire logic            switch_low_power,
   input  wire logic            agg_abandoned,
   input  wire logic [NP-1:0]   tlp_unsupported
);
   import sppm_pkg::*;
   // ****************************************
   // Turn-off window tracker
   // ****************************************
   logic pend;
   logic next_pend;

   always_comb begin
      next_pend = (pend | turnoff_rx) & ~ack_tx & ~(pend & tlp_rx[0]);
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pend <= 1'b0;
      end else begin
         pend <= next_pend;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   ctx_kept_a: assert property (
      $past(resetn) |-> &context_kept_flag)
      else $error("context kept flag low");
   d3_entry_a: assert property (
      ps_wr[1] && power_state_field[3:2] == 2'h3
      && pstate_out[3:2] == SPPM_D0_ACTIVE
      |-> ##2 pstate_out[3:2] == SPPM_D3_HOT)
      else $error("port did not enter D3hot");
   bad_code_a: assert property (
      ps_wr[1] && power_state_field[3:2] inside {2'h1, 2'h2}
      |-> ##2 pstate_out[3:2] == $past(pstate_out[3:2], 2))
      else $error("unsupported code changed state");
   port_iso_a: assert property (
      ps_wr == 4'h2
      |-> ##2 pstate_out[5:4] == $past(pstate_out[5:4], 2))
      else $error("neighbour port state changed");
   l1_req_a: assert property (
      pstate_out[3:2] == SPPM_D3_HOT |-> ##[0:2] link_l1_req[1])
      else $error("no L1 request in D3hot");
   sec_ur_a: assert property (
      tlp_rx[1] && tlp_secondary[1] && tlp_is_request[1]
      && pstate_out[3:2] == SPPM_D3_HOT |=> tlp_unsupported[1])
      else $error("secondary request not flagged");
   fwd_active_a: assert property (
      turnoff_rx |=> turnoff_fwd == ($past(link_active) & 4'he))
      else $error("turn-off not forwarded to active ports");
   abandon_a: assert property (
      pend && tlp_rx[0] && !ack_tx |=> agg_abandoned)
      else $error("aggregation not abandoned");
   ack_l23_a: assert property (
      ack_tx |-> link_l23_req[0])
      else $error("ack without upstream L2/L3 request");
   low_pwr_a: assert property (
      ack_tx && pstate_out[1:0] == SPPM_D3_HOT |-> ##[0:1] switch_low_power)
      else $error("switch did not enter low power");
endmodule

bind sppm_top sppm_top_monitor #(.NP(NP)) u_mon (.mclk, .resetn, .ps_wr,
   .power_state_field, .turnoff_rx, .link_active, .tlp_rx, .tlp_secondary,
   .tlp_is_request, .context_kept_flag, .pstate_out, .link_l1_req,
   .turnoff_fwd, .link_l23_req, .ack_tx, .switch_low_power, .agg_abandoned,
   .tlp_unsupported);

// [sppm_top_tb_top.sv]
// Self-checking bench of the power management block
`timescale 1ns/1ps
module sppm_top_tb_top;
   import sppm_pkg::*;
   localparam int NP = 4;
   localparam int TW = 24;
   localparam int WTO = 8;
   localparam int ATO = 16;
   logic            mclk = 1'b0;
   logic            resetn = 1'b0;
   logic [NP-1:0]   cfg_done = '0;
   logic [NP-1:0]   ps_wr = '0;
   logic [2*NP-1:0] power_state_field = '0;
   logic [NP-1:0]   wake_status_clr = '0;
   logic [NP-1:0]   hp_event = '0;
   logic [NP-1:0]   link_active = '1;
   logic [NP-1:0]   link_in_l0 = '1;
   logic            turnoff_rx = 1'b0;
   logic            tlp_to_switch = 1'b0;
   logic [NP-1:0]   tlp_rx = '0;
   logic [NP-1:0]   tlp_secondary = '0, tlp_is_request = '0, tlp_cfg0 = '0;
   logic [NP-1:0]   tlp_msg_local = '0, tlp_cpl_local = '0;
   logic [NP-1:0]   err_from_tlp = '0, err_other = '0;
   logic [NP-1:0]   tlp_dest = 4'h2;
   logic [7:0]      ack_delay [NP] = '{default: 8'h0};
   logic [NP-1:0]   ack_rx, context_kept_flag, wake_event_status;
   logic [NP-1:0]   wake_msg_send, link_l1_req, turnoff_fwd, link_l23_req;
   logic [NP-1:0]   link_retrain, tlp_forward, tlp_unsupported;
   logic [NP-1:0]   tlp_unexpected_cpl, tlp_process, err_msg_send;
   logic [2*NP-1:0] pstate_out;
   logic            ack_tx, switch_low_power, agg_abandoned;
   logic [10:0]     tbl [7] = '{11'h302, 11'h282, 11'h208, 11'h608,
                                11'h044, 11'h021, 11'h010};
   int              n_fail = 0;
   int              check_count = 0;
   int              n;
   int              k;

   sppm_top #(.NP(NP), .TW(TW)) u_dut (.mclk, .resetn, .cfg_done, .ps_wr,
      .power_state_field, .wake_resend_timeout({NP{TW'(WTO)}}),
      .turnoff_ack_timeout({NP{TW'(ATO)}}), .wake_status_clr, .hp_event,
      .link_active, .link_in_l0, .turnoff_rx, .ack_rx, .tlp_rx,
      .tlp_secondary, .tlp_is_request, .tlp_cfg0, .tlp_msg_local,
      .tlp_cpl_local, .tlp_to_switch, .tlp_dest, .err_from_tlp,
      .err_other, .context_kept_flag, .pstate_out, .wake_event_status,
      .wake_msg_send, .link_l1_req, .turnoff_fwd, .link_l23_req,
      .link_retrain, .tlp_forward, .ack_tx, .switch_low_power,
      .agg_abandoned, .tlp_unsupported, .tlp_unexpected_cpl, .tlp_process,
      .err_msg_send);

   sppm_far_end #(.NP(NP)) u_far (.mclk, .resetn, .turnoff_fwd, .ack_delay,
      .ack_rx);

   always #2.5 mclk = ~mclk;

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic tk(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // A wait that ran out of cycles ends the run
   task automatic bound(input int c, input int m);
      if (c >= m) begin
         chk(8'h1, 8'h0);
         print_verdict();
      end
   endtask

   task automatic do_reset();
      resetn = 1'b0;
      cfg_done = '0;
      repeat (5) @(posedge mclk);
      #1;
      resetn = 1'b1;
   endtask

   task automatic ps_set(input int p, input logic [1:0] c);
      ps_wr[p] = 1'b1;
      power_state_field[2*p +: 2] = c;
      tk(1);
      ps_wr[p] = 1'b0;
      tk(3);
   endtask

   task automatic tlp(input int p, input logic [6:0] c);
      tlp_rx[p] = 1'b1;
      {tlp_secondary[p], tlp_is_request[p], tlp_cfg0[p], tlp_msg_local[p],
       tlp_cpl_local[p], err_from_tlp[p], err_other[p]} = c;
      tk(1);
      tlp_rx[p] = 1'b0;
      {tlp_secondary[p], tlp_is_request[p], tlp_cfg0[p], tlp_msg_local[p],
       tlp_cpl_local[p], err_from_tlp[p], err_other[p]} = 7'h00;
   endtask

   task automatic turn_off();
      turnoff_rx = 1'b1;
      tk(1);
      turnoff_rx = 1'b0;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      do_reset();
      tk(1);
      chk(pstate_out, 8'h00);
      chk(context_kept_flag, 8'h0f);
      cfg_done = '1;
      tk(3);
      chk(pstate_out, 8'h55);
      ps_set(1, 2'h3);
      chk(pstate_out, 8'h59);
      chk(link_l1_req, 8'h02);
      ps_set(1, 2'h1);
      ps_set(1, 2'h2);
      chk(pstate_out, 8'h59);
      for (int i = 0; i < 7; i++) begin
         tlp(1, tbl[i][10:4]);
         chk({tlp_unsupported[1], tlp_unexpected_cpl[1],
            tlp_process[1], err_msg_send[1]},
            tbl[i][3:0]);
         tk(1);
      end
      cfg_done[1] = 1'b0;
      ps_set(1, 2'h0);
      chk(pstate_out[3:2], 2'h0);
      chk(context_kept_flag, 8'h0f);
      cfg_done[1] = 1'b1;
      tk(3);
      chk(pstate_out[3:2], 2'h1);
      // A request for the switch itself stays local, other errors escape D0
      tlp_to_switch = 1'b1;
      tlp(0, 7'h21);
      chk({tlp_forward, tlp_process[0], err_msg_send[0]},
         8'h03);
      tlp_to_switch = 1'b0;
      $display("test states done");
      // Hot-plug wake resend
      ps_set(2, 2'h3);
      hp_event[2] = 1'b1;
      tk(1);
      hp_event[2] = 1'b0;
      for (n = 0; n < 20 && wake_msg_send[2] !== 1'b1; n++) tk(1);
      bound(n, 20);
      chk(wake_event_status[2], 1'b1);
      tk(1);
      for (n = 1; n < 40 && wake_msg_send[2] !== 1'b1; n++) tk(1);
      chk(n, WTO);
      wake_status_clr[2] = 1'b1;
      tk(1);
      wake_status_clr[2] = 1'b0;
      k = 0;
      repeat (3 * WTO) begin
         tk(1);
         if (wake_msg_send[2] !== 1'b0) k++;
      end
      chk(k, 0);
      $display("test wake done");
      // Aggregation with one silent port
      do_reset();
      cfg_done = '1;
      link_active = 4'hb;
      ack_delay[1] = 8'h3;
      tk(3);
      ps_set(0, 2'h3);
      turn_off();
      chk(turnoff_fwd, 8'h0a);
      for (n = 0; n < 60 && ack_tx !== 1'b1; n++) tk(1);
      bound(n, 60);
      chk(n >= ATO, 1'b1);
      chk({link_l23_req[3], link_l23_req[0]}, 2'h3);
      tk(1);
      chk(switch_low_power, 1'b1);
      // Whole switch in D3hot lets an awake port raise a wake message
      hp_event[2] = 1'b1;
      tk(1);
      hp_event[2] = 1'b0;
      tk(1);
      chk(wake_msg_send[2], 1'b1);
      tlp(0, 7'h20);
      chk({agg_abandoned, tlp_forward}, 8'h00);
      $display("test aggregation done");
      // Abandonment by an upstream request to a sleeping port
      do_reset();
      cfg_done = '1;
      link_active = 4'ha;
      link_in_l0 = 4'h2;
      ack_delay[1] = 8'h1e;
      tk(3);
      turn_off();
      tk(1);
      tlp_dest = 4'h8;
      tlp(0, 7'h20);
      chk(agg_abandoned, 1'b1);
      for (n = 0; n < 10 && link_retrain[3] !== 1'b1; n++) tk(1);
      bound(n, 10);
      chk(tlp_forward[3], 1'b0);
      link_in_l0[3] = 1'b1;
      for (n = 0; n < 10 && tlp_forward[3] !== 1'b1; n++) tk(1);
      bound(n, 10);
      k = 0;
      repeat (40) begin
         tk(1);
         if (ack_tx !== 1'b0) k++;
      end
      chk(k, 0);
      $display("test abandon done");
      print_verdict();
   end
endmodule
